// *** hw/result_route_top.sv ***
// What this block does
// - route code 0..3 sends a channel event to service request line 0..3
// - route fields sit at 1:0, 5:4, 9:8, 13:12; gap bits read zero
// - channel 0 request drives the input mux with its substitute number
// - channel 1 request drives the input mux with its substitute number
// - all other actions and the sync request use the requested channel
// - each channel's target pointer picks the result register; sharing allowed
// - one valid flag per result register marks new unread data
// - unreduced result sits with msb at 11; every store sets valid and event
// - reduced view shows overflow at 13:12; valid and event only at sequence end
// - clearing views clear valid
// - debug views return the same value without touching valid
// - standard view includes channel number and clears valid
// - accumulated view omits channel, clears valid; its debug twin does not
// - hold-until-read blocks requests while valid or already converting it
// - under hold-until-read next request waits for the read-out
// - a started conversion to the same held register is not aborted
// - higher request to another register cancels and later repeats the lower
// - result event or written one sets the event flag; zero does nothing
// - writing one to the clear register clears the matching event flag
// - result events and flag writes pulse the selected service request line
// - result register 0..7 events sit at event flag positions 8..15
// - channel 8..15 events and flag writes pulse the selected service request line
// - standard view: result at 11:2, channel number at 15:12
//
// top of the result handling and event routing block, avalon-mm slave
// assumes: converter answers conv_done_i once per start, in order
`include "result_route_map.svh"
module result_route_top
  import result_route_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [15:0] conv_pend_i,
  input  wire logic [15:0] chan_event_i,
  input  wire logic        conv_done_i,
  input  wire logic [9:0]  conv_data_i,
  output logic             conv_start_o,
  output logic             conv_abort_o,
  output logic [3:0]       mux_sel_o,
  output logic [3:0]       conv_chan_o,
  output logic             sync_req_o,
  output logic [3:0]       service_request_line_o
);
  typedef struct packed {
    logic [15:0]     route8;
    logic [15:0]     route12;
    logic [15:0]     subst;
    logic [15:0]     ch_flags;
    logic [15:0]     ev_flags;
    logic [15:0]     ev_route_lo;
    logic [15:0]     ev_route_hi;
    logic [15:0][15:0] ch_ctrl;
    logic [7:0][5:0] res_ctrl;
    conv_state_type  cs;
    logic [3:0]      cur_ch;
    logic [2:0]      cur_tgt;
    logic            start;
    logic            abort;
    logic [3:0]      mux;
    logic            sync;
    logic [3:0]      srl;
    logic [31:0]     rdata;
    logic            ack;
  } st_type;
  st_type r_r, r_nxt;

  conv_req_if req_if ();
  conv_arbiter arb_u (.port_a(req_if));

  logic [7:0]       store_v;
  logic [7:0]       clr_v;
  logic [7:0][15:0] std_v;
  logic [7:0][15:0] acc_v;
  logic [7:0]       valid_v;
  logic [7:0]       rev_v;
  logic [15:0]      hold_ok;

  function automatic logic [2:0] target_of(input logic [15:0] ctrl);
    target_of = ctrl[`CH_TARGET_LSB +: 3];
  endfunction

  function automatic logic [1:0] route_code(input logic [15:0] reg_v, input logic [1:0] idx);
    route_code = reg_v[{idx, 2'b00} +: 2];
  endfunction

  function automatic logic [3:0] onehot4(input logic [1:0] code);
    onehot4 = 4'h1 << code;
  endfunction

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : res_g
      result_store rs_u (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .store_i   (store_v[g]),
        .data_i    (conv_data_i),
        .chan_i    (r_r.cur_ch),
        .reduce_i  (r_r.res_ctrl[g][`RES_CTRL_REDUCE_LSB +: 2]),
        .clr_i     (clr_v[g]),
        .std_o     (std_v[g]),
        .acc_o     (acc_v[g]),
        .valid_o   (valid_v[g]),
        .event_o   (rev_v[g])
      );
    end
  endgenerate

  logic        acc_go;
  logic [7:0]  a_idx;
  logic [2:0]  view_n;
  logic        in_std;
  logic        in_acc;
  logic        in_dbg;
  logic        in_adbg;
  assign acc_go  = (avs_read || avs_write) && !r_r.ack;
  assign a_idx   = avs_address;
  assign view_n  = a_idx[3:1];
  assign in_std  = (a_idx & 8'hf0) == `OFS_STD_VIEW_BASE;
  assign in_acc  = (a_idx & 8'hf0) == `OFS_ACC_VIEW_BASE;
  assign in_dbg  = (a_idx & 8'hf0) == `OFS_DBG_VIEW_BASE;
  assign in_adbg = (a_idx & 8'hf0) == `OFS_ACC_DBG_VIEW_BASE;

  // only the clearing views strip valid; debug views leave it
  always_comb begin
    clr_v   = 8'h00;
    store_v = 8'h00;
    if (acc_go && avs_read && (in_std || in_acc) && !a_idx[0]) begin
      clr_v[view_n] = 1'b1;
    end
    if (r_r.cs == CONV_RUN && conv_done_i) begin
      store_v[r_r.cur_tgt] = 1'b1;
    end
  end

  // a channel may start only if its held target is empty and not being filled
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      logic [2:0] t;
      t = target_of(r_r.ch_ctrl[i]);
      hold_ok[i] = !r_r.res_ctrl[t][`RES_CTRL_HOLD_BIT]
                   || (!valid_v[t] && !(r_r.cs == CONV_RUN && r_r.cur_tgt == t));
    end
  end
  assign req_if.pend    = conv_pend_i;
  assign req_if.gate_ok = hold_ok;
  assign req_if.abort   = 1'b0;

  always_comb begin
    logic [15:0] wd;
    logic [15:0] ch_set;
    logic [7:0]  rd_sel;
    logic [2:0]  gtgt;
    wd     = avs_writedata[15:0];
    ch_set = 16'h0000;
    rd_sel = 8'h00;
    gtgt   = target_of(r_r.ch_ctrl[req_if.grant_ch]);
    r_nxt  = r_r;
    r_nxt.start = 1'b0;
    r_nxt.abort = 1'b0;
    r_nxt.srl   = 4'h0;
    r_nxt.ack   = 1'b0;
    if (acc_go) begin
      r_nxt.ack   = 1'b1;
      r_nxt.rdata = 32'h0000_0000;
      if (avs_write) begin
        unique case (a_idx)
          `OFS_EVENT_ROUTE_CH8_11:  r_nxt.route8 = wd & `ROUTE_MASK;
          `OFS_EVENT_ROUTE_CH12_15: r_nxt.route12 = wd & `ROUTE_MASK;
          `OFS_CHANNEL_SUBST:       r_nxt.subst = wd & `SUBST_MASK;
          `OFS_CHANNEL_FLAGS:       ch_set = wd;
          `OFS_EVENT_FLAGS:         rd_sel = wd[`RESULT_EVENT_LSB +: 8];
          `OFS_RESULT_ROUTE_LOW:    r_nxt.ev_route_lo = wd & `ROUTE_MASK;
          `OFS_RESULT_ROUTE_HIGH:   r_nxt.ev_route_hi = wd & `ROUTE_MASK;
          default: begin
            if ((a_idx & 8'he0) == `OFS_CH_CTRL_BASE && !a_idx[0]) begin
              r_nxt.ch_ctrl[a_idx[4:1]] = wd & `CH_CTRL_MASK;
            end else if ((a_idx & 8'hf0) == `OFS_RESULT_CTRL_BASE && !a_idx[0]) begin
              r_nxt.res_ctrl[view_n] = {wd[5:4], 3'b000, wd[0]};
            end
          end
        endcase
      end else begin
        unique case (a_idx)
          `OFS_EVENT_ROUTE_CH8_11:  r_nxt.rdata[15:0] = r_r.route8;
          `OFS_EVENT_ROUTE_CH12_15: r_nxt.rdata[15:0] = r_r.route12;
          `OFS_CHANNEL_SUBST:       r_nxt.rdata[15:0] = r_r.subst;
          `OFS_CHANNEL_FLAGS:       r_nxt.rdata[15:0] = r_r.ch_flags;
          `OFS_EVENT_FLAGS:         r_nxt.rdata[15:0] = r_r.ev_flags;
          `OFS_RESULT_ROUTE_LOW:    r_nxt.rdata[15:0] = r_r.ev_route_lo;
          `OFS_RESULT_ROUTE_HIGH:   r_nxt.rdata[15:0] = r_r.ev_route_hi;
          `OFS_VALID_FLAGS:         r_nxt.rdata[7:0] = valid_v;
          default: begin
            if ((in_std || in_dbg) && !a_idx[0]) begin
              r_nxt.rdata[15:0] = std_v[view_n];
            end else if ((in_acc || in_adbg) && !a_idx[0]) begin
              r_nxt.rdata[15:0] = acc_v[view_n];
            end else if ((a_idx & 8'he0) == `OFS_CH_CTRL_BASE && !a_idx[0]) begin
              r_nxt.rdata[15:0] = r_r.ch_ctrl[a_idx[4:1]];
            end else if ((a_idx & 8'hf0) == `OFS_RESULT_CTRL_BASE && !a_idx[0]) begin
              r_nxt.rdata[15:0] = {10'h000, r_r.res_ctrl[view_n][5:4], 3'b000, r_r.res_ctrl[view_n][0]};
            end
          end
        endcase
      end
    end
    // channel events 8..15: set wins over clear; pulse the routed line
    for (int c = 8; c < 16; c++) begin
      if (chan_event_i[c] || ch_set[c]) begin
        r_nxt.srl = r_nxt.srl | onehot4(route_code(c < 12 ? r_r.route8 : r_r.route12, c[1:0]));
      end
    end
    if (acc_go && avs_write && a_idx == `OFS_CHANNEL_FLAGS_CLR) begin
      r_nxt.ch_flags = r_nxt.ch_flags & ~wd;
    end
    r_nxt.ch_flags = r_nxt.ch_flags | chan_event_i | ch_set;
    // result events land at flag positions 8..15
    for (int k = 0; k < 8; k++) begin
      if (rev_v[k] || rd_sel[k]) begin
        r_nxt.srl = r_nxt.srl | onehot4(route_code(k < 4 ? r_r.ev_route_lo : r_r.ev_route_hi, k[1:0]));
      end
    end
    if (acc_go && avs_write && a_idx == `OFS_EVENT_FLAGS_CLR) begin
      r_nxt.ev_flags = r_nxt.ev_flags & ~wd;
    end
    r_nxt.ev_flags[`RESULT_EVENT_LSB +: 8] = r_nxt.ev_flags[`RESULT_EVENT_LSB +: 8] | rev_v | rd_sel;
    // conversion sequencing
    unique case (r_r.cs)
      CONV_IDLE: begin
        if (req_if.grant) begin
          r_nxt.cs      = CONV_RUN;
          r_nxt.cur_ch  = req_if.grant_ch;
          r_nxt.cur_tgt = gtgt;
          r_nxt.start   = 1'b1;
          r_nxt.sync    = r_r.ch_ctrl[req_if.grant_ch][7];
          unique case (req_if.grant_ch)
            4'h0:    r_nxt.mux = r_r.subst[`SUBST_ZERO_LSB +: 4];
            4'h1:    r_nxt.mux = r_r.subst[`SUBST_ONE_LSB +: 4];
            default: r_nxt.mux = req_if.grant_ch;
          endcase
        end
      end
      CONV_RUN: begin
        if (conv_done_i) begin
          r_nxt.cs   = CONV_IDLE;
          r_nxt.sync = 1'b0;
        end else if (req_if.grant && req_if.grant_ch > r_r.cur_ch && gtgt != r_r.cur_tgt) begin
          r_nxt.cs    = CONV_IDLE;
          r_nxt.abort = 1'b1;
          r_nxt.sync  = 1'b0;
        end
        // same target: the running conversion stays
      end
      default: r_nxt.cs = CONV_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      r_r       <= '0;
      r_r.subst <= `SUBST_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign avs_readdata           = r_r.rdata;
  assign avs_waitrequest        = !r_r.ack;
  assign conv_start_o           = r_r.start;
  assign conv_abort_o           = r_r.abort;
  assign mux_sel_o              = r_r.mux;
  assign conv_chan_o            = r_r.cur_ch;
  assign sync_req_o             = r_r.sync;
  assign service_request_line_o = r_r.srl;

  a_route_ch8: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    chan_event_i[8] |=> service_request_line_o[$past(r_r.route8[1:0])]) else $error("ch8 event misrouted");
  a_route_gap: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (r_r.route12 & ~`ROUTE_MASK) == 16'h0000) else $error("route gap bits set");
  a_subst_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    r_r.cs == CONV_IDLE && req_if.grant && req_if.grant_ch == 4'h0
    |=> conv_start_o && mux_sel_o == $past(r_r.subst[3:0]) && conv_chan_o == 4'h0) else $error("ch0 mux wrong");
  a_subst_one: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    r_r.cs == CONV_IDLE && req_if.grant && req_if.grant_ch == 4'h1
    |=> mux_sel_o == $past(r_r.subst[11:8]) && conv_chan_o == 4'h1) else $error("ch1 mux wrong");
  a_hold_block: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    conv_start_o |-> !$past(r_r.res_ctrl[r_r.cur_tgt][0]) || !$past(valid_v[r_r.cur_tgt]))
    else $error("start while held register valid");
  a_event_set: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rev_v[0] |=> r_r.ev_flags[8]) else $error("result event flag not set");
  a_result_route: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rev_v[0] |=> service_request_line_o[$past(r_r.ev_route_lo[1:0])]) else $error("result event misrouted");
  sequence s_ev_clear;
    acc_go && avs_write && a_idx == `OFS_EVENT_FLAGS_CLR && avs_writedata[9] && !rev_v[1];
  endsequence
  a_event_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    s_ev_clear |=> !r_r.ev_flags[9]) else $error("event flag not cleared");
  a_bus_answer: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus answer late");
endmodule

// *** hw/result_route_map.svh ***
// register offsets, field positions and reset values for the result/event routing block
// assumes: included by the package and the design modules; definitions only
`ifndef RESULT_ROUTE_MAP_SVH
`define RESULT_ROUTE_MAP_SVH
// word offsets on the register bus (byte address = index * 4)
`define OFS_EVENT_ROUTE_CH8_11    8'h9c
`define OFS_EVENT_ROUTE_CH12_15   8'h9e
`define OFS_CHANNEL_SUBST         8'ha0
`define OFS_CHANNEL_FLAGS         8'h90
`define OFS_CHANNEL_FLAGS_CLR     8'h92
`define OFS_EVENT_FLAGS           8'h94
`define OFS_EVENT_FLAGS_CLR       8'h96
`define OFS_RESULT_ROUTE_LOW      8'ha4
`define OFS_RESULT_ROUTE_HIGH     8'ha6
`define OFS_VALID_FLAGS           8'ha8
`define OFS_RESULT_CTRL_BASE      8'hb0
`define OFS_CH_CTRL_BASE          8'h20
`define OFS_STD_VIEW_BASE         8'h40
`define OFS_ACC_VIEW_BASE         8'h50
`define OFS_DBG_VIEW_BASE         8'h60
`define OFS_ACC_DBG_VIEW_BASE     8'h70
// field layout
`define ROUTE_MASK                16'h3333
`define SUBST_MASK                16'h1f1f
`define SUBST_RESET               16'h0100
`define SUBST_ZERO_LSB            0
`define SUBST_ONE_LSB             8
`define CH_CTRL_MASK              16'h7fff
`define CH_TARGET_LSB             12
`define RES_CTRL_MASK             16'h0031
`define RES_CTRL_HOLD_BIT         0
`define RES_CTRL_REDUCE_LSB       4
`define STD_CHAN_LSB              12
`define STD_RESULT_LSB            2
`define ACC_OVF_LSB               12
`define RESULT_EVENT_LSB          8
`define RESULT_MSB                11
`endif

// *** hw/result_route_pkg.sv ***
// shared types of the result handling and event routing block
// assumes: map header defines offsets and fields
package result_route_pkg;
  `include "result_route_map.svh"
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN  = 2'b01
  } conv_state_type;
  typedef logic [15:0] word_type;
endpackage

// *** hw/conv_req_if.sv ***
// request/answer bundle between the control core and the request arbiter
// assumes: single clock, same domain on both sides
interface conv_req_if;
  logic [15:0] pend;
  logic [15:0] gate_ok;
  logic        grant;
  logic [3:0]  grant_ch;
  logic        abort;
  modport core (output gate_ok, input pend, output abort, input grant, input grant_ch);
  modport arb  (input gate_ok, input pend, input abort, output grant, output grant_ch);
endinterface

// *** hw/conv_arbiter.sv ***
// picks the highest numbered gated pending channel as the next conversion
// assumes: pend and gate_ok driven by the core on the same clock
module conv_arbiter (
  conv_req_if.arb port_a
);
  always_comb begin
    port_a.grant    = 1'b0;
    port_a.grant_ch = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (port_a.pend[i] && port_a.gate_ok[i]) begin
        port_a.grant    = 1'b1;
        port_a.grant_ch = i[3:0];
      end
    end
  end
endmodule

// *** hw/result_store.sv ***
// one result register: data, channel, valid flag and reduction counter
// assumes: store and clear strobes come from the core on the same clock
module result_store
  import result_route_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        store_i,
  input  wire logic [9:0]  data_i,
  input  wire logic [3:0]  chan_i,
  input  wire logic [1:0]  reduce_i,
  input  wire logic        clr_i,
  output logic [15:0]      std_o,
  output logic [15:0]      acc_o,
  output logic             valid_o,
  output logic             event_o
);
  typedef struct packed {
    logic [13:0] acc;
    logic [3:0]  chan;
    logic [1:0]  cnt;
    logic        valid;
    logic        ev;
  } st_type;
  st_type r, nxt;
  logic [13:0] sample;
  assign sample = {2'b00, data_i, 2'b00};
  always_comb begin
    nxt    = r;
    nxt.ev = 1'b0;
    if (clr_i) begin
      nxt.valid = 1'b0;
    end
    if (store_i) begin
      nxt.chan = chan_i;
      if (reduce_i == 2'b00) begin
        nxt.acc   = sample;
        nxt.valid = 1'b1;
        nxt.ev    = 1'b1;
      end else if (r.cnt == 2'b00) begin
        nxt.acc = sample;
        nxt.cnt = reduce_i;
      end else begin
        nxt.acc = r.acc + sample;
        nxt.cnt = r.cnt - 2'b01;
        if (r.cnt == 2'b01) begin
          nxt.valid = 1'b1;
          nxt.ev    = 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) r <= '0;
    else r <= nxt;
  end
  assign std_o   = {r.chan, r.acc[11:2], 2'b00};
  assign acc_o   = {2'b00, r.acc};
  assign valid_o = r.valid;
  assign event_o = r.ev;
  a_store_valid: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    store_i && reduce_i == 2'b00 |=> valid_o && event_o) else $error("store did not set valid");
  a_clear_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clr_i && !store_i |=> !valid_o) else $error("clearing read left valid");
  a_set_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    clr_i && store_i && reduce_i == 2'b00 |=> valid_o) else $error("store lost to clear");
endmodule

// *** verif/result_route_top_test.sv ***
// self-checking bench for the result handling and event routing block
// assumes: design files compiled first; avalon-mm driven here, the converter side is played by the bench
`include "result_route_map.svh"
module result_route_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import result_route_pkg::*;
  logic        clk_sys_i, rst_n_i, avs_read, avs_write, avs_waitrequest, conv_done_i;
  logic        conv_start_o, conv_abort_o, sync_req_o;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed;
  logic [15:0] conv_pend_i, chan_event_i;
  logic [9:0]  conv_data_i, d0, d1, d2, d3;
  logic [3:0]  mux_sel_o, conv_chan_o, service_request_line_o;
  logic [15:0] exp_rd[$];
  logic [3:0]  exp_sr[$];
  int          fail_count, n_tests, starts;

  result_route_top i_dut (.clk_sys_i, .rst_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .conv_pend_i, .chan_event_i, .conv_done_i, .conv_data_i,
    .conv_start_o, .conv_abort_o, .mux_sel_o, .conv_chan_o, .sync_req_o, .service_request_line_o);

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [9:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[9:0];
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    fail_count++;
    $display("[FAIL] %s expected answer seen none", what);
    tally_and_finish();
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // request held until waitrequest is sampled low, released only after that edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int i;
    @(posedge clk_sys_i);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {16'h0000, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_sys_i);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 20) timeout("bus answer");
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask

  task automatic start_conv(input int ch, input logic [3:0] mux, input logic sync);
    int i;
    conv_pend_i[ch] <= 1'b1;
    for (i = 0; i < 30; i++) begin
      @(posedge clk_sys_i);
      if (conv_start_o === 1'b1) break;
    end
    if (i == 30) timeout("conversion start");
    check("mux select", {12'h000, mux}, {12'h000, mux_sel_o});
    check("conversion channel", ch[15:0], {12'h000, conv_chan_o});
    conv_pend_i[ch] <= 1'b0;
    @(posedge clk_sys_i);
    check("sync request", {15'h0000, sync}, {15'h0000, sync_req_o});
  endtask

  task automatic finish_conv(input logic [9:0] d, input logic [3:0] line, input logic fires);
    idle(2);
    if (fires) exp_sr.push_back(line);
    conv_data_i <= d;
    conv_done_i <= 1'b1;
    @(posedge clk_sys_i);
    conv_done_i <= 1'b0;
    idle(6);
  endtask

  // second process: takes the oldest note whenever a read answer or a service pulse appears
  always @(posedge clk_sys_i) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_rd.size() == 0) check("unexpected read", 16'h0000, 16'hffff);
      else check("read data", exp_rd.pop_front(), avs_readdata[15:0]);
    end
    if (service_request_line_o !== 4'h0) begin
      if (exp_sr.size() == 0) check("service line", 16'h0000, {12'h000, service_request_line_o});
      else check("service line", {12'h000, exp_sr.pop_front()}, {12'h000, service_request_line_o});
    end
  end

  initial begin
    rst_n_i = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h00; avs_writedata = 32'h0;
    conv_pend_i = 16'h0000; chan_event_i = 16'h0000; conv_done_i = 1'b0; conv_data_i = 10'h000;
    seed = 32'h3514ab25; fail_count = 0; n_tests = 0;
    idle(5);
    rst_n_i <= 1'b1;
    rd(`OFS_CHANNEL_SUBST, 16'h0100);
    rd(`OFS_EVENT_ROUTE_CH12_15, 16'h0000);
    rd(8'h41, 16'h0000);
    wr(8'hff, 16'hffff);
    $display("test reset and unmapped done");
    wr(`OFS_EVENT_ROUTE_CH12_15, 16'hffff);
    rd(`OFS_EVENT_ROUTE_CH12_15, 16'h3333);
    wr(`OFS_EVENT_ROUTE_CH12_15, 16'h0123);
    wr(`OFS_EVENT_ROUTE_CH8_11, 16'h3210);
    rd(`OFS_EVENT_ROUTE_CH8_11, 16'h3210);
    for (int ch = 8; ch < 16; ch++) begin
      exp_sr.push_back(4'b0001 << (ch < 12 ? ch - 8 : 15 - ch));
      chan_event_i <= 16'h0001 << ch;
      @(posedge clk_sys_i);
      chan_event_i <= 16'h0000;
      idle(6);
    end
    exp_sr.push_back(4'b0010);
    wr(`OFS_CHANNEL_FLAGS, 16'h0200);
    idle(6);
    $display("test channel routing done");
    wr(`OFS_CHANNEL_SUBST, 16'h0905);
    wr(`OFS_CH_CTRL_BASE + 8'h06, 16'h2080);
    wr(`OFS_RESULT_ROUTE_LOW, 16'h0200);
    d0 = rnd();
    d1 = rnd();
    d2 = rnd();
    start_conv(0, 4'h5, 1'b0);
    finish_conv(d0, 4'b0001, 1'b1);
    rd(`OFS_STD_VIEW_BASE, {4'h0, d0, 2'b00});
    start_conv(1, 4'h9, 1'b0);
    finish_conv(d1, 4'b0001, 1'b1);
    rd(`OFS_VALID_FLAGS, 16'h0001);
    rd(`OFS_DBG_VIEW_BASE, {4'h1, d1, 2'b00});
    rd(`OFS_ACC_DBG_VIEW_BASE, {4'h0, d1, 2'b00});
    rd(`OFS_VALID_FLAGS, 16'h0001);
    rd(`OFS_STD_VIEW_BASE, {4'h1, d1, 2'b00});
    rd(`OFS_VALID_FLAGS, 16'h0000);
    $display("test substitution and views done");
    start_conv(3, 4'h3, 1'b1);
    finish_conv(d2, 4'b0100, 1'b1);
    rd(`OFS_EVENT_FLAGS, 16'h0500);
    wr(`OFS_EVENT_FLAGS_CLR, 16'h0100);
    rd(`OFS_EVENT_FLAGS, 16'h0400);
    exp_sr.push_back(4'b0001);
    wr(`OFS_EVENT_FLAGS, 16'h0800);
    idle(6);
    wr(`OFS_EVENT_FLAGS, 16'h0000);
    rd(`OFS_EVENT_FLAGS, 16'h0c00);
    wr(`OFS_EVENT_FLAGS_CLR, 16'h0c00);
    rd(`OFS_EVENT_FLAGS, 16'h0000);
    $display("test result events done");
    // register 2 still holds unread data, so the held request must stay parked
    wr(`OFS_RESULT_CTRL_BASE + 8'h04, 16'h0001);
    starts = 0;
    conv_pend_i[3] <= 1'b1;
    repeat (20) begin
      @(posedge clk_sys_i);
      if (conv_start_o !== 1'b0) starts++;
    end
    check("start while held", 16'h0000, starts[15:0]);
    rd(`OFS_STD_VIEW_BASE + 8'h04, {4'h3, d2, 2'b00});
    d3 = rnd();
    start_conv(3, 4'h3, 1'b1);
    finish_conv(d3, 4'b0100, 1'b1);
    rd(`OFS_VALID_FLAGS, 16'h0004);
    $display("test hold until read done");
    wr(`OFS_RESULT_CTRL_BASE + 8'h04, 16'h0010);
    rd(`OFS_STD_VIEW_BASE + 8'h04, {4'h3, d3, 2'b00});
    d0 = rnd();
    d1 = rnd();
    start_conv(3, 4'h3, 1'b1);
    finish_conv(d0, 4'b0000, 1'b0);
    rd(`OFS_VALID_FLAGS, 16'h0000);
    start_conv(3, 4'h3, 1'b1);
    finish_conv(d1, 4'b0100, 1'b1);
    rd(`OFS_VALID_FLAGS, 16'h0004);
    rd(`OFS_ACC_VIEW_BASE + 8'h04, {2'b00, 12'(d0) + 12'(d1), 2'b00});
    rd(`OFS_VALID_FLAGS, 16'h0000);
    $display("test data reduction done");
    // channel 2 aims at register 1, channel 9 at register 0: the higher one cancels
    wr(`OFS_CH_CTRL_BASE + 8'h04, 16'h1000);
    start_conv(2, 4'h2, 1'b0);
    conv_pend_i[2] <= 1'b1;
    conv_pend_i[9] <= 1'b1;
    starts = 0;
    repeat (6) begin
      @(posedge clk_sys_i);
      if (conv_abort_o === 1'b1) starts++;
    end
    check("abort pulses", 16'h0001, starts[15:0]);
    check("running channel", 16'h0009, {12'h000, conv_chan_o});
    conv_pend_i[9] <= 1'b0;
    d2 = rnd();
    finish_conv(d2, 4'b0001, 1'b1);
    check("repeated channel", 16'h0002, {12'h000, conv_chan_o});
    conv_pend_i[2] <= 1'b0;
    d3 = rnd();
    finish_conv(d3, 4'b0001, 1'b1);
    $display("test cancel and repeat done");
    idle(10);
    check("pending service notes", 16'h0000, exp_sr.size());
    check("pending read notes", 16'h0000, exp_rd.size());
    tally_and_finish();
  end
endmodule
